// ==== logic/rhc_top.sv ====
/*
  supervisory logic of a chassis controller card: backplane clock, power
  admission, overheat shedding, front-panel lamps, buttons and the
  active/standby election. assumes debounced button levels, a decoded
  control-serial-bus admission request and a wishbone classic master.
*/
// How it works
// - never leave hub without active controller
// - active card drives backplane clock
// - overheat sheds area modules by class
// - admit if budget left, record consumption
// - forward admitted identity to hub manager
// - supply lamps: off/on/flash; fan lamps: on/flash
// - temperature lamp flashes while overheated
// - active lamp on active; standby flashes faulty
// - hub reset only on active, console same
// - lamp test works active or standby
// - all lamps lit about five seconds
// - both cards monitor temperature and power
// - takeover triggers fast reboot of modules if peer still present
// - hot insertion: first card in is active
// - power-up: slot 18 card active
// - after hub reset slot 18 active
// - legacy manager sees active at slot 17
`timescale 1ns/100ps
module rhc_top #(
  parameter int LAMP_ON_N = rhc_pkg::LAMP_ON_CYC,
  parameter int BLINK_N = rhc_pkg::BLINK_CYC,
  parameter int FLASH_N = rhc_pkg::FLASH_HALF_CYC,
  parameter int SLOTS = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic in_slot18_i,
  input wire logic peer_present_i,
  input wire logic peer_active_i,
  input wire logic power_on_i,
  input wire logic hub_reset_in_i,
  input wire logic reset_button_i,
  input wire logic lamp_button_i,
  input wire rhc_pkg::rhc_env_t env_i,
  input wire logic [3:0] overheat_area_i,
  input wire rhc_pkg::rhc_admit_t admit_i,
  output rhc_pkg::rhc_led_t led_o,
  output logic active_o,
  output logic backplane_clk_o,
  output logic hub_reset_o,
  output logic fast_reboot_o,
  output logic [SLOTS-1:0] slot_power_o,
  output logic lamp_all_on_o,
  output logic lamp_blink_o,
  output rhc_pkg::rhc_admit_t hub_manager_o,
  output logic [4:0] presented_slot_o
);
  import rhc_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int NS = 7 + $bits(rhc_env_t);
  logic [NS-1:0] raw_w;
  logic [NS-1:0] s1_q, s2_q;
  logic [4:0] last_q;
  assign raw_w = {in_slot18_i, peer_present_i, peer_active_i, power_on_i,
                  hub_reset_in_i, reset_button_i, lamp_button_i, env_i};
  logic slot18_w, peer_pres_w, peer_act_w, pwr_w, hreset_w, rbtn_w, lbtn_w, hot_w;
  rhc_env_t env_w;
  assign {slot18_w, peer_pres_w, peer_act_w, pwr_w, hreset_w, rbtn_w, lbtn_w, env_w} = s2_q;
  assign hot_w = env_w.over_temp;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      last_q <= 5'h00;
    end else begin
      s1_q <= raw_w;
      s2_q <= s1_q;
      last_q <= {pwr_w, hreset_w, rbtn_w, lbtn_w, peer_act_w};
    end
  end
  logic pwr_rise_w, hreset_rise_w, rbtn_rise_w, lbtn_rise_w, peer_lost_w;
  assign pwr_rise_w = pwr_w & ~last_q[4];
  assign hreset_rise_w = hreset_w & ~last_q[3];
  assign rbtn_rise_w = rbtn_w & ~last_q[2];
  assign lbtn_rise_w = lbtn_w & ~last_q[1];
  assign peer_lost_w = last_q[0] & ~peer_act_w;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic console_reset_w;
  logic legacy_q;
  logic [15:0] budget_q;
  logic [15:0] used_q;
  logic [3:0] area_mask_q;
  logic [31:0] last_id_q;
  logic active_q;
  logic wb_req_w, wb_wr_w;
  assign wb_req_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr_w = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign console_reset_w = wb_wr_w & (wb_adr_i == REG_CTRL) & wb_sel_i[0] & wb_dat_i[CTRL_RESET_BIT];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req_w;
      if (wb_req_w && !wb_we_i) begin
        case (wb_adr_i)
          REG_CTRL: wb_dat_o <= {30'h0000_0000, legacy_q, 1'b0};
          REG_STATUS: wb_dat_o <= {29'h0000_0000, fast_reboot_o, hub_reset_o, active_q};
          REG_BUDGET: wb_dat_o <= {16'h0000, budget_q};
          REG_USED: wb_dat_o <= {16'h0000, used_q};
          REG_AREA: wb_dat_o <= {28'h000_0000, area_mask_q};
          REG_ID: wb_dat_o <= last_id_q;
          default: wb_dat_o <= WB_UNMAPPED;
        endcase
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      legacy_q <= 1'b0;
      budget_q <= BUDGET_RST;
      area_mask_q <= 4'h0;
    end else if (wb_wr_w) begin
      if (wb_adr_i == REG_CTRL && wb_sel_i[0])
        legacy_q <= wb_dat_i[CTRL_LEGACY_BIT];
      if (wb_adr_i == REG_BUDGET && wb_sel_i[0])
        budget_q[7:0] <= wb_dat_i[7:0];
      if (wb_adr_i == REG_BUDGET && wb_sel_i[1])
        budget_q[15:8] <= wb_dat_i[15:8];
      if (wb_adr_i == REG_AREA && wb_sel_i[0])
        area_mask_q <= wb_dat_i[3:0];
    end
  end

  // ----------------------------------------
  // election and hub reset
  // ----------------------------------------
  logic do_reset_w;
  logic [4:0] rst_cnt_q;
  assign do_reset_w = active_q & (rbtn_rise_w | console_reset_w);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_q <= 1'b0;
    end else if (pwr_rise_w || hreset_rise_w || do_reset_w) begin
      active_q <= slot18_w | ~peer_pres_w;
    end else if (!active_q && !peer_act_w) begin
      active_q <= 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_cnt_q <= 5'h00;
      hub_reset_o <= 1'b0;
    end else begin
      if (do_reset_w)
        rst_cnt_q <= 5'(RESET_PULSE_CYC);
      else if (rst_cnt_q != 5'h00)
        rst_cnt_q <= rst_cnt_q - 5'h01;
      hub_reset_o <= do_reset_w | (rst_cnt_q > 5'h01);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_reboot_o <= 1'b0;
      active_o <= 1'b0;
      backplane_clk_o <= 1'b0;
      presented_slot_o <= SLOT_SECOND;
    end else begin
      fast_reboot_o <= ~active_q & peer_lost_w & peer_pres_w;
      active_o <= active_q;
      backplane_clk_o <= active_q & ~backplane_clk_o;
      if (legacy_q)
        presented_slot_o <= active_q ? SLOT_LEGACY : 5'h00;
      else
        presented_slot_o <= slot18_w ? SLOT_PRIMARY : SLOT_SECOND;
    end
  end

  // ----------------------------------------
  // power admission and shedding
  // ----------------------------------------
  logic [SLOTS-1:0][15:0] draw_q;
  logic [SLOTS-1:0][1:0] area_q;
  logic [SLOTS-1:0][1:0] class_q;
  logic fits_w;
  logic [15:0] shed_w;
  assign fits_w = ({1'b0, used_q} + {1'b0, admit_i.power}) <= {1'b0, budget_q};
  always_comb begin
    shed_w = 16'h0000;
    for (int k = 0; k < SLOTS; k++) begin
      if (slot_power_o[k] && hot_w && area_mask_q[area_q[k]] && class_q[k] == 2'h0)
        shed_w = shed_w + draw_q[k];
    end
  end
  generate
    for (genvar i = 0; i < SLOTS; i++) begin : g_slot
      always_ff @(posedge clk_i) begin
        if (rst_i || hub_reset_o) begin
          slot_power_o[i] <= 1'b0;
          draw_q[i] <= 16'h0000;
          area_q[i] <= 2'h0;
          class_q[i] <= 2'h0;
        end else if (admit_i.valid && admit_i.slot == 5'(i) && fits_w && !slot_power_o[i]) begin
          slot_power_o[i] <= 1'b1;
          draw_q[i] <= admit_i.power;
          area_q[i] <= admit_i.area;
          class_q[i] <= admit_i.pclass;
        end else if (hot_w && area_mask_q[area_q[i]] && class_q[i] == 2'h0) begin
          slot_power_o[i] <= 1'b0;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk_i) begin
    if (rst_i || hub_reset_o) begin
      used_q <= 16'h0000;
      last_id_q <= 32'h0000_0000;
      hub_manager_o <= '0;
    end else begin
      hub_manager_o <= '0;
      if (admit_i.valid && fits_w && !slot_power_o[admit_i.slot]) begin
        used_q <= used_q + admit_i.power - shed_w;
        last_id_q <= admit_i.identity;
        hub_manager_o <= admit_i;
      end else begin
        used_q <= used_q - shed_w;
      end
    end
  end

  // ----------------------------------------
  // lamp test and flashing
  // ----------------------------------------
  rhc_lamp_t lamp_q;
  logic [31:0] lamp_cnt_q;
  logic [31:0] flash_cnt_q;
  logic flash_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_cnt_q <= 32'h0000_0000;
      flash_q <= 1'b0;
    end else if (flash_cnt_q >= 32'(FLASH_N - 1)) begin
      flash_cnt_q <= 32'h0000_0000;
      flash_q <= ~flash_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lamp_q <= LT_IDLE;
      lamp_cnt_q <= 32'h0000_0000;
    end else begin
      case (lamp_q)
        LT_IDLE: begin
          if (lbtn_rise_w) begin
            lamp_q <= LT_ALL_ON;
            lamp_cnt_q <= 32'(LAMP_ON_N - 1);
          end
        end
        LT_ALL_ON: begin
          if (lamp_cnt_q == 32'h0000_0000) begin
            lamp_q <= LT_BLINK;
            lamp_cnt_q <= 32'(BLINK_N - 1);
          end else begin
            lamp_cnt_q <= lamp_cnt_q - 32'h0000_0001;
          end
        end
        LT_BLINK: begin
          if (lamp_cnt_q == 32'h0000_0000)
            lamp_q <= LT_IDLE;
          else
            lamp_cnt_q <= lamp_cnt_q - 32'h0000_0001;
        end
        default: lamp_q <= LT_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      led_o <= '0;
      lamp_all_on_o <= 1'b0;
      lamp_blink_o <= 1'b0;
    end else begin
      lamp_all_on_o <= (lamp_q == LT_ALL_ON);
      lamp_blink_o <= (lamp_q == LT_BLINK);
      if (lamp_q == LT_ALL_ON) begin
        led_o <= '1;
      end else begin
        led_o.sup <= env_w.sup_present & (~env_w.sup_fault | {4{flash_q}});
        led_o.fan <= ~env_w.fan_fault | {3{flash_q}};
        led_o.temp <= hot_w & flash_q;
        led_o.active <= active_q;
        led_o.standby <= env_w.card_fault & flash_q;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_RESET_ACTIVE_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(hub_reset_o) |-> $past(active_q)) else $error("hub reset from standby");
  AST_LED_ACTIVE: assert property (@(posedge clk_i) disable iff (rst_i)
    (lamp_q == LT_IDLE && $past(lamp_q) == LT_IDLE) |-> led_o.active == $past(active_q))
    else $error("active lamp mismatch");
  AST_ALL_ON: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(lamp_q) == LT_ALL_ON |-> led_o == '1) else $error("lamp test not all on");
  AST_LAMP_START: assert property (@(posedge clk_i) disable iff (rst_i)
    (lamp_q == LT_IDLE && lbtn_rise_w) |=> lamp_q == LT_ALL_ON) else $error("lamp test ignored");
  AST_TAKEOVER: assert property (@(posedge clk_i) disable iff (rst_i)
    (!active_q && !peer_act_w && !pwr_rise_w && !hreset_rise_w) |=> active_q)
    else $error("no active controller");
  AST_CLOCK_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
    (!active_q ##1 !active_q) |=> !backplane_clk_o) else $error("standby drives clock");
  AST_ADMIT_FWD: assert property (@(posedge clk_i) disable iff (rst_i || hub_reset_o)
    (admit_i.valid && fits_w && !slot_power_o[admit_i.slot]) |=> hub_manager_o.valid)
    else $error("identity not forwarded");
  AST_OVER_BUDGET: assert property (@(posedge clk_i) disable iff (rst_i || hub_reset_o)
    (admit_i.valid && !fits_w) |=> !hub_manager_o.valid) else $error("admitted over budget");
  AST_TEMP_LED: assert property (@(posedge clk_i) disable iff (rst_i)
    (!hot_w && lamp_q != LT_ALL_ON) |=> !led_o.temp) else $error("temp lamp lit while cool");
  AST_LEGACY_SLOT: assert property (@(posedge clk_i) disable iff (rst_i)
    (legacy_q && active_q) |=> presented_slot_o == SLOT_LEGACY) else $error("legacy slot wrong");
endmodule

// ==== logic/rhc_pkg.sv ====
/*
  shared constants and carrier types of the redundant hub controller.
  assumes a 10 MHz system clock and a classic wishbone register bus.
*/
package rhc_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int LAMP_ON_MS = 5000;
  localparam int LAMP_ON_CYC = LAMP_ON_MS * (CLK_HZ / 1000);
  localparam int BLINK_MS = 25000;
  localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);
  localparam int RESET_PULSE_CYC = 16;
  // ----------------------------------------
  // slots
  // ----------------------------------------
  localparam logic [4:0] SLOT_PRIMARY = 5'h12;
  localparam logic [4:0] SLOT_SECOND = 5'h13;
  localparam logic [4:0] SLOT_LEGACY = 5'h11;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_BUDGET = 8'h08;
  localparam logic [7:0] REG_USED = 8'h0c;
  localparam logic [7:0] REG_AREA = 8'h10;
  localparam logic [7:0] REG_ID = 8'h14;
  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_LEGACY_BIT = 1;
  localparam logic [15:0] BUDGET_RST = 16'h0000;
  localparam logic [31:0] WB_UNMAPPED = 32'h0000_0000;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] sup_present;
    logic [3:0] sup_fault;
    logic [2:0] fan_fault;
    logic over_temp;
    logic card_fault;
  } rhc_env_t;

  typedef struct packed {
    logic [3:0] sup;
    logic [2:0] fan;
    logic temp;
    logic active;
    logic standby;
  } rhc_led_t;

  typedef struct packed {
    logic valid;
    logic [4:0] slot;
    logic [15:0] power;
    logic [1:0] area;
    logic [1:0] pclass;
    logic [31:0] identity;
  } rhc_admit_t;

  typedef enum logic [1:0] {
    LT_IDLE,
    LT_ALL_ON,
    LT_BLINK
  } rhc_lamp_t;
endpackage

// ==== tb/rhc_far_model.sv ====
/*
  far-side model: a media module that announces itself once on insertion,
  and a hub manager that records the identities forwarded to it.
  assumes rhc_pkg and the system clock of the controller.
*/
`timescale 1ns/100ps
module rhc_far_model #(
  parameter int NET = 3,
  parameter logic [7:0] NV_CFG = 8'h3c,
  parameter logic [7:0] SW_CFG = 8'hc3
) (
  input wire logic clk_i,
  input wire logic insert_i,
  input wire rhc_pkg::rhc_admit_t req_i,
  input wire rhc_pkg::rhc_admit_t mgr_i,
  input wire logic all_on_i,
  input wire logic blink_i,
  input wire logic fast_reboot_i,
  output rhc_pkg::rhc_admit_t admit_o,
  output logic [7:0] mgr_cnt_o,
  output logic [31:0] mgr_id_o,
  output logic port_net_o,
  output logic port_free_o,
  output logic [7:0] cfg_o
);
  import rhc_pkg::*;
  localparam int AW = $bits(rhc_admit_t);
  int blinks;
  initial begin
    admit_o = '0;
    mgr_cnt_o = 8'h00;
    mgr_id_o = 32'h0000_0000;
    port_net_o = 1'b0;
    port_free_o = 1'b0;
    cfg_o = SW_CFG;
    blinks = 0;
  end
  // ----------------------------------------
  // module announce and hub manager
  // ----------------------------------------
  // released bus shows scrambled data so a stale value cannot pass as a request
  always @(posedge clk_i) begin
    if (insert_i)
      admit_o <= {1'b1, req_i[AW-2:0]};
    else
      admit_o <= {1'b0, ~admit_o[AW-2:0]};
    if (mgr_i.valid === 1'b1) begin
      mgr_cnt_o <= mgr_cnt_o + 8'h01;
      mgr_id_o <= mgr_i.identity;
    end
  end
  // ----------------------------------------
  // port lamps and fast reboot
  // ----------------------------------------
  // one port on network NET and one port with no network; the stored copy wins over the switches
  always @(posedge clk_i) begin
    if (all_on_i === 1'b1) begin
      port_net_o <= 1'b1;
      port_free_o <= 1'b1;
      blinks <= 0;
    end else if (blink_i === 1'b1) begin
      port_free_o <= 1'b0;
      if (port_net_o) begin
        port_net_o <= 1'b0;
      end else if (blinks < NET) begin
        port_net_o <= 1'b1;
        blinks <= blinks + 1;
      end
    end else begin
      port_net_o <= 1'b0;
      port_free_o <= 1'b0;
    end
    if (fast_reboot_i === 1'b1)
      cfg_o <= NV_CFG;
  end
endmodule

// ==== tb/rhc_top_tb.sv ====
/*
  self-checking bench of the hub controller with its far-side model.
  assumes rhc_pkg and shortened lamp and flash counts.
*/
`timescale 1ns/100ps
module rhc_top_tb;
  import rhc_pkg::*;
  localparam int LON = 20;
  localparam int BLN = 40;
  localparam int FLN = 4;
  localparam int NETN = 3;
  localparam logic [7:0] NVC = 8'h3c;
  localparam logic [7:0] SWC = 8'hc3;
  logic pnet, pfree, pl;
  logic [7:0] cfg;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000, rdat, rd, sp, seed = 32'h0000_580d;
  logic slot18 = 1'b1, peer_p = 1'b0, peer_a = 1'b0, hrst_in = 1'b0, rbtn = 1'b0, lbtn = 1'b0;
  logic active, bclk, hrst, frb, all_on, blink, ins = 1'b0, fr;
  rhc_env_t env = '{4'b0011, 4'b0010, 3'b001, 1'b0, 1'b0};
  rhc_admit_t admit, mgr, req = '0;
  rhc_led_t led, lo, la;
  logic [4:0] pslot;
  logic [7:0] mgr_cnt;
  logic [31:0] mgr_id;
  logic [15:0] used = 16'h0000, bud = 16'h0000, p;
  int n_mismatch = 0, num_checks = 0, i, n, nb;

  always #50 clk_i = ~clk_i;

  rhc_top #(.LAMP_ON_N(LON), .BLINK_N(BLN), .FLASH_N(FLN), .SLOTS(32)) u_rhc_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .in_slot18_i(slot18),
    .peer_present_i(peer_p), .peer_active_i(peer_a), .power_on_i(1'b1), .hub_reset_in_i(hrst_in),
    .reset_button_i(rbtn), .lamp_button_i(lbtn), .env_i(env), .overheat_area_i(4'h0),
    .admit_i(admit), .led_o(led), .active_o(active), .backplane_clk_o(bclk), .hub_reset_o(hrst),
    .fast_reboot_o(frb), .slot_power_o(sp), .lamp_all_on_o(all_on), .lamp_blink_o(blink),
    .hub_manager_o(mgr), .presented_slot_o(pslot));

  rhc_far_model #(.NET(NETN), .NV_CFG(NVC), .SW_CFG(SWC)) u_rhc_far_model (.clk_i(clk_i), .insert_i(ins),
    .req_i(req), .mgr_i(mgr), .all_on_i(all_on), .blink_i(blink), .fast_reboot_i(frb), .admit_o(admit),
    .mgr_cnt_o(mgr_cnt), .mgr_id_o(mgr_id), .port_net_o(pnet), .port_free_o(pfree), .cfg_o(cfg));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic fits(input logic [15:0] u, input logic [15:0] q, input logic [15:0] b);
    return ({1'b0, u} + {1'b0, q}) <= {1'b0, b};
  endfunction

  function automatic logic [3:0] sup_steady(input logic [3:0] pr, input logic [3:0] f);
    return pr & ~f;
  endfunction

  task chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  task watch(input int k);
    lo = '0;
    la = '1;
    repeat (k) begin
      @(posedge clk_i);
      lo = lo | led;
      la = la & led;
    end
  endtask

  // classic cycle: held until ack is sampled high, released after that edge
  task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    rd = rdat;
    chk(k < 50, "bus timeout");
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task admit_one(input logic [4:0] s, input logic [15:0] q, input logic [1:0] ar, input logic [1:0] pc);
    logic e;
    logic [7:0] c;
    e = fits(used, q, bud);
    c = mgr_cnt;
    @(posedge clk_i);
    ins <= 1'b1;
    req <= '{1'b0, s, q, ar, pc, rnd()};
    @(posedge clk_i);
    ins <= 1'b0;
    tick(3);
    chk(sp[s] === e, "slot power");
    chk(mgr_cnt === c + {7'h00, e}, "manager count");
    if (e) chk(mgr_id === req.identity, "manager identity");
    if (e) used = used + q;
  endtask

  task give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    tick(10);
    rst_i <= 1'b0;
    for (i = 0; i < 10 && active !== 1'b1; i++) @(posedge clk_i);
    chk(active === 1'b1 && led.active === 1'b1 && led.standby === 1'b0, "power-up election");
    fr = bclk;
    @(posedge clk_i);
    chk(bclk === ~fr, "backplane clock");
    $display("test election finished");
    wb(1'b1, REG_BUDGET, 4'h3, 32'h0000_0100);
    bud = 16'h0100;
    wb(1'b0, REG_BUDGET, 4'hf, 32'h0000_0000);
    chk(rd[15:0] === bud, "budget readback");
    wb(1'b0, 8'h3c, 4'hf, 32'h0000_0000);
    chk(rd === WB_UNMAPPED, "unmapped read");
    rd = rnd();
    p = {9'h000, rd[6:0]} + 16'h0001;
    admit_one(5'h05, p, 2'h1, 2'h0);
    admit_one(5'h09, bud - used + 16'h0001, 2'h1, 2'h1);
    admit_one(5'h0c, bud - used, 2'h2, 2'h1);
    wb(1'b0, REG_USED, 4'hf, 32'h0000_0000);
    chk(rd[15:0] === used, "used table");
    $display("test admission finished");
    wb(1'b1, REG_AREA, 4'h1, 32'h0000_0002);
    env.over_temp <= 1'b1;
    tick(6);
    chk(sp[5] === 1'b0 && sp[12] === 1'b1, "overheat shed");
    watch(3 * FLN);
    chk(lo.temp === 1'b1 && la.temp === 1'b0, "temperature flash");
    env.over_temp <= 1'b0;
    tick(6);
    wb(1'b0, REG_USED, 4'hf, 32'h0000_0000);
    chk(rd[15:0] === used - p, "used after shed");
    used = used - p;
    watch(3 * FLN);
    chk(lo.temp === 1'b0, "temperature normal");
    chk(la.sup === sup_steady(env.sup_present, env.sup_fault) && lo.sup === env.sup_present, "supply lamps");
    chk(la.fan === ~env.fan_fault && lo.fan === 3'b111, "fan lamps");
    env.card_fault <= 1'b1;
    watch(3 * FLN);
    chk(lo.standby === 1'b1 && la.standby === 1'b0, "fault flash");
    env.card_fault <= 1'b0;
    $display("test lamps finished");
    wb(1'b1, REG_CTRL, 4'h1, 32'h0000_0001);
    for (i = 0; i < 5 && hrst !== 1'b1; i++) @(posedge clk_i);
    n = 0;
    while (hrst === 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    chk(n == RESET_PULSE_CYC && sp === 32'h0000_0000, "console reset");
    used = 16'h0000;
    tick(8);
    chk(active === 1'b1, "slot 18 after reset");
    slot18 <= 1'b0;
    peer_p <= 1'b1;
    peer_a <= 1'b1;
    hrst_in <= 1'b1;
    tick(2);
    hrst_in <= 1'b0;
    tick(8);
    chk(active === 1'b0 && bclk === 1'b0 && led.active === 1'b0, "standby after reset");
    rbtn <= 1'b1;
    watch(20);
    rbtn <= 1'b0;
    chk(hrst === 1'b0 && active === 1'b0, "button ignored on standby");
    wb(1'b1, REG_CTRL, 4'h1, 32'h0000_0002);
    tick(2);
    chk(pslot === 5'h00, "standby hidden");
    lbtn <= 1'b1;
    tick(2);
    lbtn <= 1'b0;
    for (i = 0; i < 6 && all_on !== 1'b1; i++) @(posedge clk_i);
    chk(all_on === 1'b1, "lamp test on standby");
    n = 0;
    while (all_on === 1'b1 && n < 99) begin
      if (n == 5) chk(led === '1, "all lamps lit");
      if (n == 5) chk(pnet === 1'b1 && pfree === 1'b1, "module lamps lit");
      @(posedge clk_i);
      n++;
    end
    chk(n == LON && blink === 1'b1, "all-on span");
    n = 0;
    nb = 0;
    pl = 1'b1;
    fr = 1'b0;
    while (blink === 1'b1 && n < 99) begin
      if (pnet === 1'b1 && pl !== 1'b1) nb++;
      if (n > 0 && pfree !== 1'b0) fr = 1'b1;
      pl = pnet;
      @(posedge clk_i);
      n++;
    end
    chk(n == BLN, "blink span");
    chk(nb == NETN, "port blinks network number");
    chk(fr === 1'b0, "unassigned port dark");
    $display("test standby finished");
    peer_a <= 1'b0;
    fr = 1'b0;
    for (i = 0; i < 12; i++) begin
      @(posedge clk_i);
      fr = fr | frb;
    end
    chk(active === 1'b1 && fr === 1'b1, "takeover with fast reboot");
    chk(pslot === SLOT_LEGACY && led.standby === 1'b0, "takeover presented");
    chk(cfg === NVC, "stored configuration loaded");
    rbtn <= 1'b1;
    for (i = 0; i < 6 && hrst !== 1'b1; i++) @(posedge clk_i);
    rbtn <= 1'b0;
    chk(hrst === 1'b1, "button on active");
    tick(30);
    $display("test takeover finished");
    give_verdict();
  end

  initial begin
    tick(5000);
    n_mismatch++;
    give_verdict();
  end
endmodule
